// ### pkg/sar_adc_pkg.sv
// constants, pin layout and state encodings for the serial converter control port
package sar_adc_pkg;
    localparam int RESULT_WIDTH = 16;
    localparam int SHIFT_PULSES = 16;
    localparam int CLK_PERIOD_NS = 4;
    // conversion time, longest figure, rounded down
    localparam int CONV_TIME_NS = 3000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CONV_CNT_W = $clog2(CONV_CYCLES);
    // convert edge to first internal data bit; the generated shift clock rises one quarter period later
    localparam int SCLK_DELAY_NS = 260;
    localparam int SCLK_DELAY_CYCLES = SCLK_DELAY_NS / CLK_PERIOD_NS;
    localparam int SCLK_DELAY_W = $clog2(SCLK_DELAY_CYCLES);
    // generated shift clock period, cut in four quarters
    localparam int SCLK_PERIOD_NS = 150;
    localparam int SCLK_QUARTER_CYCLES = SCLK_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int SCLK_QUARTER_W = $clog2(SCLK_QUARTER_CYCLES);
    localparam int BIT_IDX_W = $clog2(SHIFT_PULSES);
    // positions of the synchronised pins
    localparam int PIN_CS = 0;
    localparam int PIN_RC = 1;
    localparam int PIN_TAG = 2;
    localparam int PIN_FMT = 3;
    localparam int PIN_EXT = 4;
    localparam int PIN_PD = 5;
    localparam int PIN_COUNT = 6;
    // select and read/convert idle high, everything else low
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h03;
    localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;
    localparam logic [1:0] SETTLE_RESET = 2'h0;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_RUN = 2'b10
    } conv_state_e;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_DELAY = 3'b010,
        SH_SHIFT = 3'b100
    } shift_state_e;
endpackage

// ### design/ext_shift_link.sv
// shift register clocked by the externally supplied serial shift clock
`timescale 1ns/1ps
module ext_shift_link (
    input wire logic i_link_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_read_convert,
    input wire logic i_tag,
    input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] i_result_word,
    input wire logic i_idle_level,
    output logic o_data,
    output logic o_sync
);
    import sar_adc_pkg::*;

    logic [1:0] rst_meta_reg;
    logic rst_reg;
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    logic win_prev_reg;
    logic [RESULT_WIDTH-1:0] sr_reg;
    logic win;
    logic win_rise;

    // reset is only seen once the host runs the clock
    always_ff @(posedge i_link_clk) begin
        rst_meta_reg <= {rst_meta_reg[0], i_srst};
        rst_reg <= rst_meta_reg[1];
    end

    always_ff @(posedge i_link_clk) begin
        if (rst_reg) begin
            pin_meta_reg <= PIN_RESET[1:0];
            pin_sync_reg <= PIN_RESET[1:0];
            win_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {i_read_convert, i_cs_n};
            pin_sync_reg <= pin_meta_reg;
            win_prev_reg <= win;
        end
    end

    assign win = ~pin_sync_reg[0] & pin_sync_reg[1];
    assign win_rise = win & ~win_prev_reg;

    // result word is quasi-static: it only changes at the end of a conversion or when the format select changes
    always_ff @(posedge i_link_clk) begin
        if (rst_reg) begin
            sr_reg <= RESULT_RESET;
            o_data <= 1'b0;
            o_sync <= 1'b0;
        end else if (win_rise) begin
            sr_reg <= {i_result_word[RESULT_WIDTH-2:0], i_tag};
            o_data <= i_result_word[RESULT_WIDTH-1];
            o_sync <= 1'b1;
        end else if (win) begin
            o_data <= sr_reg[RESULT_WIDTH-1];
            sr_reg <= {sr_reg[RESULT_WIDTH-2:0], i_tag};
            o_sync <= 1'b0;
        end else begin
            o_data <= i_idle_level;
            o_sync <= 1'b0;
        end
    end

    chk_sync_single_pulse: assert property (@(posedge i_link_clk) disable iff (rst_reg)
        win_rise |=> o_sync ##1 !o_sync)
        else $error("sync pulse not exactly one link clock");
    chk_tag_enters_chain: assert property (@(posedge i_link_clk) disable iff (rst_reg)
        (win && !win_rise) |=> sr_reg[0] == $past(i_tag))
        else $error("tag level not shifted into chain");
    chk_first_bit_msb: assert property (@(posedge i_link_clk) disable iff (rst_reg)
        win_rise |=> o_data == $past(i_result_word[RESULT_WIDTH-1]))
        else $error("first external bit is not the msb");
endmodule

// ### design/sar_adc_control.sv
// control, conversion timing and serial output of the sar converter
// Overview of operation
// - select low, convert falling edge starts conversion
// - read/convert low, select falling edge starts conversion
// - select low, convert rising edge enables output
// - convert high, select falling edge enables output
// - busy low throughout conversion, result valid rising
// - both low at busy rise restarts at once
// - format high straight binary, low two's complement
// - external mode shifts on host shift clock
// - internal mode sends previous result, 16 pulses
// - internal shift clock low between conversions
// - internal mode data stable at both edges
// - external mode output enable gives one sync
// - tag shifted out delayed sixteen clocks
// - idle data holds tag from conversion start
// - power down inhibits conversions, keeps result
// - start requests ignored during conversion
// - conversion end loads result into output
`timescale 1ns/1ps
module sar_adc_control (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_read_convert,
    input wire logic i_tag,
    input wire logic i_output_format_select,
    input wire logic i_shift_clock_source_select,
    input wire logic i_power_down_input,
    input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] i_sar_result,
    input wire logic i_serial_shift_clock,
    output logic o_busy_n,
    output logic o_sample_hold,
    output logic o_data,
    output logic o_sync,
    output logic o_serial_shift_clock,
    output logic o_serial_shift_clock_oe
);
    import sar_adc_pkg::*;

    logic [PIN_COUNT-1:0] pin_meta_reg;
    logic [PIN_COUNT-1:0] pin_sync_reg;
    logic [PIN_COUNT-1:0] pin_prev_reg;
    logic [1:0] settle_reg;
    logic cs_q;
    logic rc_q;
    logic pd_q;
    logic ext_q;
    logic fmt_q;
    logic select_or;
    logic select_or_prev;
    logic conv_req;
    logic conv_end;
    logic start_now;
    conv_state_e conv_state_reg;
    logic [CONV_CNT_W-1:0] conv_cnt_reg;
    logic busy_n_reg;
    logic restart_reg;
    logic [RESULT_WIDTH-1:0] result_reg;
    logic [RESULT_WIDTH-1:0] out_word_reg;
    logic [RESULT_WIDTH-1:0] fmt_word;
    logic tag_hold_reg;
    shift_state_e sh_state_reg;
    logic [SCLK_DELAY_W-1:0] delay_cnt_reg;
    logic [SCLK_QUARTER_W-1:0] tick_reg;
    logic [1:0] quarter_reg;
    logic [BIT_IDX_W-1:0] bit_reg;
    logic [RESULT_WIDTH-1:0] sr_reg;
    logic sclk_reg;
    logic int_data_reg;
    logic oe_reg;
    logic link_data;
    logic link_sync;
    logic quarter_end;
    logic [CONV_CNT_W-1:0] low_len_reg;

    // every pin passes two flops before use, except tag, which the link shifts in directly
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_meta_reg <= PIN_RESET;
            pin_sync_reg <= PIN_RESET;
            pin_prev_reg <= PIN_RESET;
            settle_reg <= SETTLE_RESET;
        end else begin
            pin_meta_reg <= {i_power_down_input, i_shift_clock_source_select,
                i_output_format_select, i_tag, i_read_convert, i_cs_n};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
            settle_reg <= {settle_reg[0], 1'b1};
        end
    end

    assign cs_q = pin_sync_reg[PIN_CS];
    assign rc_q = pin_sync_reg[PIN_RC];
    assign pd_q = pin_sync_reg[PIN_PD];
    assign ext_q = pin_sync_reg[PIN_EXT];
    assign fmt_q = pin_sync_reg[PIN_FMT];
    // select and read/convert act as one or-ed strobe
    assign select_or = cs_q | rc_q;
    assign select_or_prev = pin_prev_reg[PIN_CS] | pin_prev_reg[PIN_RC];
    assign conv_req = select_or_prev & ~select_or;
    assign conv_end = (conv_state_reg == CONV_RUN) && (conv_cnt_reg == '0);
    // a request seen while running is dropped, not queued
    assign start_now = ~pd_q & (conv_state_reg == CONV_IDLE)
        & (conv_req | (restart_reg & ~select_or));

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            conv_state_reg <= CONV_IDLE;
            conv_cnt_reg <= '0;
            busy_n_reg <= 1'b1;
            restart_reg <= 1'b0;
        end else begin
            restart_reg <= conv_end;
            case (conv_state_reg)
                CONV_IDLE: begin
                    if (start_now) begin
                        conv_state_reg <= CONV_RUN;
                        conv_cnt_reg <= CONV_CNT_W'(CONV_CYCLES - 1);
                        busy_n_reg <= 1'b0;
                    end
                end
                CONV_RUN: begin
                    if (conv_end) begin
                        conv_state_reg <= CONV_IDLE;
                        busy_n_reg <= 1'b1;
                    end else begin
                        conv_cnt_reg <= conv_cnt_reg - 1'b1;
                    end
                end
                default: begin
                    conv_state_reg <= CONV_IDLE;
                    busy_n_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            result_reg <= RESULT_RESET;
            tag_hold_reg <= 1'b0;
        end else begin
            if (conv_end) begin
                result_reg <= i_sar_result;
            end
            if (start_now) begin
                tag_hold_reg <= pin_sync_reg[PIN_TAG];
            end
        end
    end

    // the converter core is offset binary; two's complement flips the msb
    assign fmt_word = {result_reg[RESULT_WIDTH-1] ^ ~fmt_q,
        result_reg[RESULT_WIDTH-2:0]};

    // registered copy handed to the link domain
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_word_reg <= RESULT_RESET;
        end else begin
            out_word_reg <= fmt_word;
        end
    end

    // busy-low length for the span check, far too long for a sequence
    always_ff @(posedge i_clk) begin
        if (i_srst || busy_n_reg) begin
            low_len_reg <= '0;
        end else begin
            low_len_reg <= low_len_reg + 1'b1;
        end
    end

    assign quarter_end = (tick_reg == SCLK_QUARTER_W'(SCLK_QUARTER_CYCLES - 1));

    // data changes in the first quarter, clock rises in the second and falls
    // in the fourth, so both edges see settled data
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sh_state_reg <= SH_IDLE;
            delay_cnt_reg <= '0;
            tick_reg <= '0;
            quarter_reg <= 2'h0;
            bit_reg <= '0;
            sr_reg <= RESULT_RESET;
            sclk_reg <= 1'b0;
            int_data_reg <= 1'b0;
        end else if (start_now && !ext_q) begin
            sh_state_reg <= SH_DELAY;
            sr_reg <= fmt_word;
            delay_cnt_reg <= SCLK_DELAY_W'(SCLK_DELAY_CYCLES - 1);
            sclk_reg <= 1'b0;
        end else begin
            case (sh_state_reg)
                SH_IDLE: begin
                    sclk_reg <= 1'b0;
                    int_data_reg <= tag_hold_reg;
                end
                SH_DELAY: begin
                    if (delay_cnt_reg == '0) begin
                        sh_state_reg <= SH_SHIFT;
                        tick_reg <= '0;
                        quarter_reg <= 2'h0;
                        bit_reg <= '0;
                        int_data_reg <= sr_reg[RESULT_WIDTH-1];
                        sr_reg <= {sr_reg[RESULT_WIDTH-2:0], 1'b0};
                    end else begin
                        delay_cnt_reg <= delay_cnt_reg - 1'b1;
                    end
                end
                SH_SHIFT: begin
                    if (!quarter_end) begin
                        tick_reg <= tick_reg + 1'b1;
                    end else begin
                        tick_reg <= '0;
                        quarter_reg <= quarter_reg + 1'b1;
                        if (quarter_reg == 2'h0) begin
                            sclk_reg <= 1'b1;
                        end else if (quarter_reg == 2'h2) begin
                            sclk_reg <= 1'b0;
                        end else if (quarter_reg == 2'h3) begin
                            if (bit_reg == BIT_IDX_W'(SHIFT_PULSES - 1)) begin
                                sh_state_reg <= SH_IDLE;
                                int_data_reg <= tag_hold_reg;
                            end else begin
                                bit_reg <= bit_reg + 1'b1;
                                int_data_reg <= sr_reg[RESULT_WIDTH-1];
                                sr_reg <= {sr_reg[RESULT_WIDTH-2:0], 1'b0};
                            end
                        end
                    end
                end
                default: begin
                    sh_state_reg <= SH_IDLE;
                    sclk_reg <= 1'b0;
                end
            endcase
        end
    end

    // pin drive waits for the mode strap to settle so reset never fights the host
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= ~ext_q & settle_reg[1];
        end
    end

    ext_shift_link u_link (
        .i_link_clk(i_serial_shift_clock),
        .i_srst(i_srst),
        .i_cs_n(i_cs_n),
        .i_read_convert(i_read_convert),
        .i_tag(i_tag),
        .i_result_word(out_word_reg),
        .i_idle_level(tag_hold_reg),
        .o_data(link_data),
        .o_sync(link_sync)
    );

    // the mode strap is static in use, so muxing across domains is safe
    assign o_data = ext_q ? link_data : int_data_reg;
    assign o_sync = ext_q & link_sync;
    assign o_busy_n = busy_n_reg;
    assign o_sample_hold = ~busy_n_reg;
    assign o_serial_shift_clock = sclk_reg;
    assign o_serial_shift_clock_oe = oe_reg;

    chk_start_on_convert: assert property (@(posedge i_clk) disable iff (i_srst)
        (conv_state_reg == CONV_IDLE && !pd_q && !cs_q && pin_prev_reg[PIN_RC] && !rc_q)
        |=> !o_busy_n && o_sample_hold)
        else $error("convert edge with select low did not start");
    chk_start_on_select: assert property (@(posedge i_clk) disable iff (i_srst)
        (conv_state_reg == CONV_IDLE && !pd_q && !rc_q && pin_prev_reg[PIN_CS] && !cs_q)
        |=> !o_busy_n)
        else $error("select edge with convert low did not start");
    chk_busy_low_span: assert property (@(posedge i_clk) disable iff (i_srst)
        $rose(o_busy_n) |-> low_len_reg == CONV_CNT_W'(CONV_CYCLES))
        else $error("busy low time wrong");
    chk_busy_low_bound: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_busy_n |-> low_len_reg < CONV_CNT_W'(CONV_CYCLES))
        else $error("busy stayed low too long");
    chk_restart_no_gap: assert property (@(posedge i_clk) disable iff (i_srst)
        ($rose(o_busy_n) && !select_or && !pd_q) |=> !o_busy_n)
        else $error("no immediate restart with both strobes low");
    chk_format_load: assert property (@(posedge i_clk) disable iff (i_srst)
        (start_now && !ext_q) |=> sr_reg[RESULT_WIDTH-1] == ($past(result_reg[RESULT_WIDTH-1])
        ^ ~$past(fmt_q)))
        else $error("output format bit wrong");
    chk_pulse_count_end: assert property (@(posedge i_clk) disable iff (i_srst)
        (sh_state_reg == SH_SHIFT && quarter_end && quarter_reg == 2'h3 && bit_reg == 4'hF
        && !start_now) |=> sh_state_reg == SH_IDLE && !sclk_reg)
        else $error("generated clock did not stop after sixteen pulses");
    chk_sclk_idle_low: assert property (@(posedge i_clk) disable iff (i_srst)
        (sh_state_reg != SH_SHIFT) |=> !sclk_reg)
        else $error("generated shift clock not low between conversions");
    chk_data_at_edges: assert property (@(posedge i_clk) disable iff (i_srst)
        (sh_state_reg == SH_SHIFT && $changed(sclk_reg)) |-> $stable(int_data_reg))
        else $error("internal data moved at a clock edge");
    chk_pd_holds_result: assert property (@(posedge i_clk) disable iff (i_srst)
        (pd_q && conv_state_reg == CONV_IDLE) |=> $stable(result_reg) && o_busy_n)
        else $error("power down did not inhibit conversion");
    chk_no_restart_run: assert property (@(posedge i_clk) disable iff (i_srst)
        (conv_state_reg == CONV_RUN && conv_cnt_reg > 1) |=> conv_state_reg == CONV_RUN
        && conv_cnt_reg == $past(conv_cnt_reg) - 1'b1)
        else $error("conversion restarted while running");
    chk_result_load: assert property (@(posedge i_clk) disable iff (i_srst)
        conv_end |=> result_reg == $past(i_sar_result) && o_busy_n)
        else $error("result not loaded at conversion end");
endmodule

// ### test/host_capture.sv
// host side model: link clock source and serial word capture
`timescale 1ns/1ps
module host_capture (
    input wire logic i_link_en,
    input wire logic i_clear,
    input wire logic i_ext,
    input wire logic i_pin_clk,
    input wire logic i_data,
    input wire logic i_sync,
    output logic o_link_clk,
    output logic [31:0] o_word_rise,
    output logic [31:0] o_word_fall,
    output logic [31:0] o_word_ext,
    output logic [7:0] o_pulses,
    output logic [7:0] o_syncs
);
    logic [7:0] ext_cnt;
    // runs only when asked, so never inside a conversion
    initial begin
        o_link_clk = 1'b0;
        forever begin
            if (i_link_en === 1'b1) begin
                #62.5 o_link_clk = 1'b1;
                #62.5 o_link_clk = 1'b0;
            end else begin
                @(i_link_en);
            end
        end
    end
    always @(posedge i_pin_clk or posedge i_clear) begin
        if (i_clear) begin
            o_word_rise <= '0;
            o_pulses <= '0;
        end else if (!i_ext) begin
            o_word_rise <= {o_word_rise[30:0], i_data};
            o_pulses <= o_pulses + 8'h01;
        end
    end
    // external mode samples mid-period, away from the launching rise
    always @(negedge i_pin_clk or posedge i_clear) begin
        if (i_clear) begin
            o_word_fall <= '0;
            o_word_ext <= '0;
            ext_cnt <= '0;
            o_syncs <= '0;
        end else if (!i_ext) begin
            o_word_fall <= {o_word_fall[30:0], i_data};
        end else if (i_sync || (ext_cnt != 8'h00 && ext_cnt < 8'h20)) begin
            o_word_ext <= {o_word_ext[30:0], i_data};
            ext_cnt <= i_sync ? 8'h01 : ext_cnt + 8'h01;
            o_syncs <= o_syncs + {7'h00, i_sync};
        end
    end
endmodule

// ### test/sar_adc_control_tb_top.sv
// self-checking bench for the serial converter control port
`timescale 1ns/1ps
module sar_adc_control_tb_top;
    import sar_adc_pkg::*;
    localparam logic [15:0] VAL_A = 16'hA5C3;
    localparam logic [15:0] VAL_B = 16'h1E7F;
    localparam logic [15:0] VAL_D = 16'hC0DE;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cs_n = 1'b1;
    logic read_convert = 1'b1;
    logic tag = 1'b0;
    logic fmt_sel = 1'b1;
    logic ext_sel = 1'b0;
    logic pwr_down = 1'b0;
    logic [15:0] sar_result = 16'h0000;
    logic link_en = 1'b0;
    logic clear = 1'b0;
    logic busy_n, sample_hold, data, sync, sclk, sclk_oe, link_clk, pin_clk;
    logic [31:0] word_rise, word_fall, word_ext;
    logic [7:0] pulses, syncs;
    int cyc = 0;
    int error_cnt = 0;
    int n_compared = 0;
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // shared clock pin: device drives it only with its enable up
    assign pin_clk = sclk_oe ? sclk : link_clk;
    sar_adc_control uut (.i_clk(clk), .i_srst(srst), .i_cs_n(cs_n),
        .i_read_convert(read_convert), .i_tag(tag), .i_output_format_select(fmt_sel),
        .i_shift_clock_source_select(ext_sel), .i_power_down_input(pwr_down),
        .i_sar_result(sar_result), .i_serial_shift_clock(pin_clk), .o_busy_n(busy_n),
        .o_sample_hold(sample_hold), .o_data(data), .o_sync(sync),
        .o_serial_shift_clock(sclk), .o_serial_shift_clock_oe(sclk_oe));
    host_capture host (.i_link_en(link_en), .i_clear(clear), .i_ext(ext_sel),
        .i_pin_clk(pin_clk), .i_data(data), .i_sync(sync), .o_link_clk(link_clk),
        .o_word_rise(word_rise), .o_word_fall(word_fall), .o_word_ext(word_ext),
        .o_pulses(pulses), .o_syncs(syncs));
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_busy(input logic lvl, input int bound, output int n);
        n = 0;
        while (busy_n !== lvl) begin
            tick(1);
            n++;
            if (n > bound) begin
                error_cnt++;
                $display("mismatch busy wait expected %b seen timeout", lvl);
                wrap_up();
            end
        end
    endtask
    task automatic clear_host();
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
    endtask
    // one conversion, with a start request thrown in while busy
    task automatic do_conv(input bit by_cs, input logic t, input logic [15:0] val);
        int n;
        int c0;
        @(posedge clk);
        tag <= t;
        sar_result <= val;
        if (by_cs) read_convert <= 1'b0;
        else cs_n <= 1'b0;
        @(posedge clk);
        if (by_cs) cs_n <= 1'b0;
        else read_convert <= 1'b0;
        #1;
        wait_busy(1'b0, 8, n);
        c0 = cyc;
        check("start delay", (n >= 3 && n <= 4), 1);
        check("hold state", sample_hold, 1);
        @(posedge clk);
        tag <= ~t;
        read_convert <= 1'b1;
        repeat (4) @(posedge clk);
        read_convert <= 1'b0;
        repeat (4) @(posedge clk);
        read_convert <= 1'b1;
        cs_n <= 1'b1;
        #1;
        wait_busy(1'b1, 1000, n);
        check("busy low cycles", cyc - c0, CONV_CYCLES);
        check("sample released", sample_hold, 0);
        tick(3);
        check("no restart", busy_n, 1);
    endtask
    task automatic test_power_down();
        @(posedge clk);
        pwr_down <= 1'b1;
        sar_result <= 16'hFFFF;
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        @(posedge clk);
        read_convert <= 1'b0;
        tick(20);
        check("power down start", busy_n, 1);
        @(posedge clk);
        read_convert <= 1'b1;
        cs_n <= 1'b1;
        repeat (4) @(posedge clk);
        pwr_down <= 1'b0;
        tick(4);
        $display("test power down done");
    endtask
    task automatic test_restart();
        int n;
        int c0;
        @(posedge clk);
        cs_n <= 1'b0;
        @(posedge clk);
        read_convert <= 1'b0;
        #1;
        wait_busy(1'b0, 8, n);
        wait_busy(1'b1, 1000, n);
        c0 = cyc;
        wait_busy(1'b0, 8, n);
        check("restart gap", cyc - c0, 1);
        @(posedge clk);
        read_convert <= 1'b1;
        cs_n <= 1'b1;
        #1;
        wait_busy(1'b1, 1000, n);
        $display("test restart done");
    endtask
    task automatic test_ext();
        // link side resets from the shift clock, so it must run here
        @(posedge clk);
        ext_sel <= 1'b1;
        srst <= 1'b1;
        link_en <= 1'b1;
        repeat (200) @(posedge clk);
        srst <= 1'b0;
        link_en <= 1'b0;
        repeat (40) @(posedge clk);
        do_conv(1, 0, VAL_D);
        clear_host();
        @(posedge clk);
        tag <= 1'b1;
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        link_en <= 1'b1;
        repeat (1250) @(posedge clk);
        link_en <= 1'b0;
        tick(40);
        check("ext word", word_ext, {VAL_D, 16'hFFFF});
        check("sync count", syncs, 1);
        check("clock pin released", sclk_oe, 0);
        @(posedge clk);
        cs_n <= 1'b1;
        link_en <= 1'b1;
        repeat (250) @(posedge clk);
        link_en <= 1'b0;
        tick(40);
        check("ext idle data", data, 0);
        $display("test external done");
    endtask
    // convert, then open the output by raising read/convert with select low
    task automatic test_ext_read();
        int n;
        @(posedge clk);
        tag <= 1'b0;
        sar_result <= VAL_B;
        read_convert <= 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        #1;
        wait_busy(1'b0, 8, n);
        @(posedge clk);
        read_convert <= 1'b1;
        #1;
        wait_busy(1'b1, 1000, n);
        clear_host();
        @(posedge clk);
        link_en <= 1'b1;
        repeat (1250) @(posedge clk);
        link_en <= 1'b0;
        tick(40);
        check("ext read word", word_ext, {VAL_B, 16'h0000});
        check("ext read sync", syncs, 1);
        @(posedge clk);
        cs_n <= 1'b1;
        tick(4);
        $display("test external read done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        tick(4);
        do_conv(0, 0, VAL_A);
        clear_host();
        do_conv(0, 1, VAL_B);
        check("internal word", word_rise[15:0], VAL_A);
        check("pulse count", pulses, SHIFT_PULSES);
        check("both edges", word_fall, word_rise);
        check("clock idle", sclk, 0);
        check("idle data", data, 1);
        $display("test internal done");
        test_power_down();
        @(posedge clk);
        fmt_sel <= 1'b0;
        clear_host();
        do_conv(1, 0, VAL_A);
        check("twos word", word_rise[15:0], VAL_B ^ 16'h8000);
        check("idle data low", data, 0);
        $display("test format done");
        @(posedge clk);
        fmt_sel <= 1'b1;
        test_restart();
        test_ext();
        test_ext_read();
        wrap_up();
    end
endmodule
